// [fhi_irq_status.sv]
// Interrupt status, receive byte count and address match logic with APB access
`timescale 1ns/10ps

module fhi_irq_status
	import fhi_pkg::*;
#(
	parameter int MS_CYCLES = MS_CYCLES_DEF
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [9:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Events and levels from the datapaths
	input wire fhi_evt_t evt,
	input wire fhi_lvl_t lvl,
	input wire logic [7:0] rx_addr,
	input wire logic [63:0] cas_data,
	// Status and control outputs
	output logic irq,
	output logic low_addr_match,
	output logic tx_disable,
	output logic sig_copy
);

	typedef struct packed {
		logic [7:0] irq_status_0;
		logic [7:0] irq_status_1;
		logic [7:0] irq_status_2;
		logic [7:0] mask0;
		logic [7:0] mask1;
		logic [7:0] mask2;
		logic [7:0] cfg;
		logic [7:0] cmp1;
		logic [7:0] cmp2;
		logic [11:0] byte_cnt;
		logic cnt_ovf;
		logic [11:0] rx_len;
		logic cnt_exceed;
		logic addr_match;
		logic [31:0] prdata;
		logic p_flost;
		logic p_mflost;
		logic p_ones;
		logic p_nosig;
		logic p_rra;
		logic p_sim;
		logic p_prbs;
		logic [2:0] p_sa6;
		logic [63:0] cas_prev;
		logic [19:0] ms_div;
		logic [8:0] ms_cnt;
		logic [4:0] llb_ms;
		fhi_llb_t llb;
		logic tx_dis;
		logic sig_copy;
		logic mfb_pend;
	} fhi_state_t;

	fhi_state_t s_reg;
	fhi_state_t s_next;
	logic [7:0] ev0, ev1, ev2, add0, add1, add2;
	logic [7:0] set0, set1, set2, rdata, sum;
	logic [7:0] idx;
	logic [11:0] cnt_now;
	logic setup, acc_rd, acc_wr, mapped, ms_tick, hdlc, show_m, chg_mode;
	logic [1:0] fmt;

	// Gate events by mask unless masked flags are to be shown
	function automatic logic [7:0] gate(input logic [7:0] e, input logic [7:0] m,
		input logic v);
		gate = v ? e : (e & ~m);
	endfunction : gate

	// Address decode and bus phases
	assign idx = paddr[9:2];
	assign setup = psel & ~penable;
	assign acc_rd = psel & penable & ~pwrite;
	assign acc_wr = psel & penable & pwrite;
	assign mapped = (paddr[1:0] == 2'h0) & ((idx >= IDX_RX_STAT && idx <= IDX_STAT2) ||
		(idx >= IDX_MASK0 && idx <= IDX_SUM));
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	// Configuration fields
	assign show_m = s_reg.cfg[CF_SHOW_MASKED];
	assign chg_mode = s_reg.cfg[CF_CHANGE_MODE];
	assign hdlc = s_reg.cfg[CF_HDLC];
	assign fmt = s_reg.cfg[CF_FMT_LO +: 2];

	// Summary and interrupt output
	// interrupt from unmasked
	assign sum = {5'h00, |(s_reg.irq_status_2 & ~s_reg.mask2), |(s_reg.irq_status_1 & ~s_reg.mask1),
		|(s_reg.irq_status_0 & ~s_reg.mask0)};
	assign irq = |sum;
	assign prdata = s_reg.prdata;
	assign low_addr_match = s_reg.addr_match;
	assign tx_disable = s_reg.tx_dis;
	assign sig_copy = s_reg.sig_copy;

	// Next-state logic
	always_comb begin
		s_next = s_reg;
		ev0 = 8'h00;
		ev1 = 8'h00;
		ev2 = 8'h00;
		// Millisecond enable divider
		ms_tick = (s_reg.ms_div == 20'(MS_CYCLES - 1));
		s_next.ms_div = ms_tick ? 20'h00000 : s_reg.ms_div + 20'h00001;

		// Receive byte counting
		cnt_now = evt.rx_start ? 12'h000 : s_reg.byte_cnt;
		if (evt.rx_start) begin
			s_next.cnt_ovf = 1'b0;
		end
		if (hdlc && evt.rx_byte) begin
			if (cnt_now == MAX_FRAME_BYTES) begin
				s_next.cnt_ovf = 1'b1;
			end else begin
				cnt_now = cnt_now + 12'h001;
			end
			if (cnt_now == FRM_START_BYTES) begin
				ev0[B0_FRM_START] = 1'b1;
			end
			if (cnt_now[4:0] == 5'h00 && !evt.rx_end) begin
				ev0[B0_POOL_FULL] = 1'b1;
			end
		end
		s_next.byte_cnt = cnt_now;
		if (hdlc && evt.rx_addr_valid) begin
			if (rx_addr == s_reg.cmp1) begin
				s_next.addr_match = 1'b1;
			end else if (rx_addr == s_reg.cmp2) begin
				s_next.addr_match = 1'b0;
			end
		end
		if (hdlc && evt.rx_end) begin
			ev0[B0_MSG_END] = 1'b1;
			s_next.rx_len = cnt_now;
			s_next.cnt_exceed = s_next.cnt_ovf;
		end
		ev1[B1_RX_OVF] = evt.rx_overflow;

		// Transmit side
		// pool ready
		ev1[B1_POOL_READY] = evt.tx_pool_free & ~s_reg.tx_dis;
		ev1[B1_ALL_SENT] = hdlc & evt.tx_last_bit & lvl.tx_fifo_empty;
		if (evt.tx_byte_req && lvl.tx_fifo_empty && !lvl.tx_message_end_cmd && !s_reg.tx_dis)
		begin
			ev1[B1_UNDERRUN] = 1'b1;
		end
		s_next.sig_copy = evt.tx_mf_start;
		s_next.mfb_pend = evt.tx_mf_start;
		ev1[B1_TX_MF] = s_reg.mfb_pend;

		// Multiframe search timeouts
		// timers after basic frame found
		if (s_reg.cfg[CF_MF_EN] && !lvl.frame_lost && lvl.multiframe_lost_flag) begin
			if (ms_tick && s_reg.ms_cnt != T_LONG_MS) begin
				s_next.ms_cnt = s_reg.ms_cnt + 9'h001;
				ev0[B0_TMO_SHORT] = (s_reg.ms_cnt == T_SHORT_MS - 9'h001);
				ev2[B2_T400] = (s_reg.ms_cnt == T_LONG_MS - 9'h001);
			end
		end else begin
			s_next.ms_cnt = 9'h000;
		end
		ev0[B0_MF_BEGIN] = (fmt == FMT_DFRAME_00) ? evt.rx_dframe : evt.rx_mf_start;
		if (evt.cas_update) begin
			s_next.cas_prev = cas_data;
			ev0[B0_CAS_CHG] = lvl.ts16_sync & (cas_data != s_reg.cas_prev);
		end
		ev0[B0_CRC] = evt.submf_done & evt.crc_fail;
		s_next.p_sa6 = lvl.sa6_combo;
		ev0[B0_SA6] = ~lvl.frame_lost & (lvl.sa6_combo != s_reg.p_sa6);

		s_next.p_prbs = lvl.prbs_sync;
		if (s_reg.cfg[CF_PRBS_SEL]) begin
			ev1[B1_LLB] = lvl.prbs_sync ^ s_reg.p_prbs;
			s_next.llb_ms = 5'h00;
			s_next.llb = LLB_IDLE;
		end else begin
			unique case (s_reg.llb)
				LLB_IDLE: begin
					if ((lvl.llb_act || lvl.llb_deact) && !lvl.ber_high) begin
						if (ms_tick) begin
							s_next.llb_ms = s_reg.llb_ms + 5'h01;
						end
						if (ms_tick && s_reg.llb_ms == LLB_HOLD_MS - 5'h01) begin
							ev1[B1_LLB] = 1'b1;
							s_next.llb = LLB_DET;
						end
					end else begin
						s_next.llb_ms = 5'h00;
					end
				end
				LLB_DET: begin
					s_next.llb_ms = 5'h00;
					if (lvl.ber_high) begin
						ev1[B1_LLB] = 1'b1;
						s_next.llb = LLB_IDLE;
					end
				end
			endcase
		end

		// Frame alignment and alarms
		s_next.p_flost = lvl.frame_lost;
		s_next.p_mflost = lvl.multiframe_lost_flag;
		s_next.p_ones = lvl.all_ones_alarm;
		s_next.p_nosig = lvl.signal_absent;
		s_next.p_rra = lvl.remote_alarm;
		s_next.p_sim = lvl.alarm_sim;
		ev2[B2_FRM_LOST] = (lvl.frame_lost & ~s_reg.p_flost) | lvl.alarm_sim;
		ev2[B2_FRM_REGAIN] = (~lvl.frame_lost & s_reg.p_flost) |
			(s_reg.p_sim & ~lvl.alarm_sim & ~lvl.frame_lost);
		ev2[B2_MF_REGAIN] = fmt[1] & ((~lvl.multiframe_lost_flag & s_reg.p_mflost) |
			(s_reg.p_sim & ~lvl.alarm_sim & ~lvl.multiframe_lost_flag));
		// alarms on detect or sim; all-ones and no-signal also on change
		ev2[B2_ALL_ONES] = lvl.alarm_sim | (chg_mode ? (lvl.all_ones_alarm ^ s_reg.p_ones) :
			(lvl.all_ones_alarm & ~s_reg.p_ones));
		ev2[B2_NO_SIGNAL] = lvl.alarm_sim | (chg_mode ? (lvl.signal_absent ^ s_reg.p_nosig) :
			(lvl.signal_absent & ~s_reg.p_nosig));
		ev2[B2_RA] = lvl.alarm_sim | (lvl.remote_alarm & ~s_reg.p_rra);
		ev2[B2_RAR] = (~lvl.remote_alarm & s_reg.p_rra) |
			(s_reg.p_sim & ~lvl.alarm_sim & ~lvl.remote_alarm);

		add0 = gate(ev0, s_reg.mask0, show_m);
		add1 = gate(ev1, s_reg.mask1, show_m);
		add2 = gate(ev2, s_reg.mask2, show_m);
		// Underrun must block transmit even if its flag is hidden
		if (ev1[B1_UNDERRUN]) begin
			s_next.tx_dis = 1'b1;
		end
		set0 = s_reg.irq_status_0 | add0;
		set1 = s_reg.irq_status_1 | add1;
		set2 = s_reg.irq_status_2 | add2;

		s_next.irq_status_0 = (acc_rd && mapped && idx == IDX_STAT0) ? add0 : set0;
		s_next.irq_status_1 = (acc_rd && mapped && idx == IDX_STAT1) ? add1 : set1;
		s_next.irq_status_2 = (acc_rd && mapped && idx == IDX_STAT2) ? add2 : set2;
		if (acc_rd && mapped && idx == IDX_STAT1 && !ev1[B1_UNDERRUN]) begin
			s_next.tx_dis = 1'b0;
		end

		// Read data mux, captured in the setup phase
		unique case (idx)
			IDX_RX_STAT: rdata = {7'h00, s_reg.addr_match};
			IDX_CNT_LO: rdata = s_reg.rx_len[7:0];
			IDX_CNT_HI: rdata = {3'h0, s_reg.cnt_exceed, s_reg.rx_len[11:8]};
			IDX_STAT0: rdata = set0;
			IDX_STAT1: rdata = set1;
			IDX_STAT2: rdata = set2;
			IDX_MASK0: rdata = s_reg.mask0;
			IDX_MASK1: rdata = s_reg.mask1;
			IDX_MASK2: rdata = s_reg.mask2;
			IDX_CFG: rdata = s_reg.cfg;
			IDX_CMP1: rdata = s_reg.cmp1;
			IDX_CMP2: rdata = s_reg.cmp2;
			IDX_SUM: rdata = sum;
			default: rdata = 8'h00;
		endcase
		if (setup) begin
			s_next.prdata = (mapped && !pwrite) ? {24'h000000, rdata} : 32'h00000000;
		end

		// Register writes
		if (acc_wr && mapped) begin
			unique case (idx)
				IDX_MASK0: s_next.mask0 = pwdata[7:0];
				IDX_MASK1: s_next.mask1 = pwdata[7:0];
				IDX_MASK2: s_next.mask2 = pwdata[7:0];
				IDX_CFG: s_next.cfg = pwdata[7:0];
				IDX_CMP1: s_next.cmp1 = pwdata[7:0];
				IDX_CMP2: s_next.cmp2 = pwdata[7:0];
				default: s_next.cfg = s_reg.cfg;
			endcase
		end
	end

	// State register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_reg <= '0;
			s_reg.irq_status_0 <= STATUS_RST;
			s_reg.irq_status_1 <= STATUS_RST;
			s_reg.irq_status_2 <= STATUS_RST;
			s_reg.mask0 <= MASK_RST;
			s_reg.mask1 <= MASK_RST;
			s_reg.mask2 <= MASK_RST;
			s_reg.cfg <= CFG_RST;
			s_reg.cmp1 <= CMP_RST;
			s_reg.cmp2 <= CMP_RST;
			s_reg.llb <= LLB_IDLE;
		end else begin
			s_reg <= s_next;
		end
	end

	// Checks
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_read_clears: assert property (
		(acc_rd && idx == IDX_STAT0 && paddr[1:0] == 2'h0) |=> (s_reg.irq_status_0 == $past(add0)))
		else $error("status 0 not cleared by read");
	a_irq_unmasked: assert property (
		((s_reg.irq_status_1 & ~s_reg.mask1) != 8'h00) |-> irq)
		else $error("interrupt missing for unmasked status");
	a_masked_silent: assert property (
		(((s_reg.irq_status_0 & ~s_reg.mask0) | (s_reg.irq_status_1 & ~s_reg.mask1) |
		(s_reg.irq_status_2 & ~s_reg.mask2)) == 8'h00) |-> !irq)
		else $error("interrupt from masked status");
	a_frame_start: assert property (
		(hdlc && (show_m || !s_reg.mask0[B0_FRM_START]) && evt.rx_byte && !evt.rx_start &&
		s_reg.byte_cnt == 12'h001) |=> s_reg.irq_status_0[B0_FRM_START])
		else $error("frame start not flagged at second byte");
	a_msg_end_len: assert property (
		(hdlc && (show_m || !s_reg.mask0[B0_MSG_END]) && evt.rx_end && evt.rx_byte &&
		!evt.rx_start && s_reg.byte_cnt < MAX_FRAME_BYTES)
		|=> s_reg.irq_status_0[B0_MSG_END] && s_reg.rx_len == $past(s_reg.byte_cnt) + 12'h001)
		else $error("message end or length wrong");
	a_count_exceed: assert property (
		(hdlc && evt.rx_end && s_next.cnt_ovf) |=> s_reg.cnt_exceed)
		else $error("count exceeded not set");
	a_addr_match: assert property (
		(hdlc && evt.rx_addr_valid && rx_addr == s_reg.cmp1) |=> low_addr_match)
		else $error("first compare match not reported");
	a_underrun_hold: assert property (
		(tx_disable && !(acc_rd && idx == IDX_STAT1)) |=> tx_disable)
		else $error("transmitter re-enabled without read");
	a_copy_then_flag: assert property (
		(evt.tx_mf_start && (show_m || !s_reg.mask1[B1_TX_MF])) |=> sig_copy ##1
		s_reg.irq_status_1[B1_TX_MF])
		else $error("signaling copy not followed by flag");
	a_short_timeout: assert property (
		(ev0[B0_TMO_SHORT]) |-> (s_reg.ms_cnt == T_SHORT_MS - 9'h001) &&
		lvl.multiframe_lost_flag)
		else $error("short timeout at wrong time");

	c_msg_end: cover property (evt.rx_end ##1 acc_rd && idx == IDX_CNT_LO);
	c_underrun: cover property (ev1[B1_UNDERRUN] ##[1:20] !tx_disable);
	c_llb_det: cover property (s_reg.llb == LLB_DET);
	c_irq_cleared: cover property (irq ##1 !irq);

endmodule : fhi_irq_status

// [fhi_pkg.sv]
// Package: register map, field positions, timing and carrier types of the status block
package fhi_pkg;

	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_RX_STAT = 8'h65;
	localparam logic [7:0] IDX_CNT_LO = 8'h66;
	localparam logic [7:0] IDX_CNT_HI = 8'h67;
	localparam logic [7:0] IDX_STAT0 = 8'h68;
	localparam logic [7:0] IDX_STAT1 = 8'h69;
	localparam logic [7:0] IDX_STAT2 = 8'h6A;
	localparam logic [7:0] IDX_MASK0 = 8'h70;
	localparam logic [7:0] IDX_MASK1 = 8'h71;
	localparam logic [7:0] IDX_MASK2 = 8'h72;
	localparam logic [7:0] IDX_CFG = 8'h73;
	localparam logic [7:0] IDX_CMP1 = 8'h74;
	localparam logic [7:0] IDX_CMP2 = 8'h75;
	localparam logic [7:0] IDX_SUM = 8'h76;

	// Status register 0 bits
	localparam int B0_MSG_END = 7;
	localparam int B0_FRM_START = 6;
	localparam int B0_TMO_SHORT = 5;
	localparam int B0_MF_BEGIN = 4;
	localparam int B0_CAS_CHG = 3;
	localparam int B0_CRC = 2;
	localparam int B0_SA6 = 1;
	localparam int B0_POOL_FULL = 0;
	// Status register 1 bits
	localparam int B1_LLB = 7;
	localparam int B1_RX_OVF = 6;
	localparam int B1_ALL_SENT = 5;
	localparam int B1_UNDERRUN = 4;
	localparam int B1_TX_MF = 3;
	localparam int B1_POOL_READY = 0;
	// Status register 2 bits
	localparam int B2_FRM_REGAIN = 7;
	localparam int B2_FRM_LOST = 6;
	localparam int B2_MF_REGAIN = 5;
	localparam int B2_T400 = 4;
	localparam int B2_ALL_ONES = 3;
	localparam int B2_NO_SIGNAL = 2;
	localparam int B2_RAR = 1;
	localparam int B2_RA = 0;
	// Count-high fields
	localparam int BH_CNT_EXCEED = 4;
	// Configuration fields
	localparam int CF_SHOW_MASKED = 0;
	localparam int CF_CHANGE_MODE = 1;
	localparam int CF_PRBS_SEL = 2;
	localparam int CF_FMT_LO = 3;
	localparam int CF_MF_EN = 5;
	localparam int CF_HDLC = 6;

	// Reset values
	localparam logic [7:0] STATUS_RST = 8'h00;
	localparam logic [7:0] MASK_RST = 8'hFF;
	localparam logic [7:0] CFG_RST = 8'h00;
	localparam logic [7:0] CMP_RST = 8'h00;

	// Receive format codes
	localparam logic [1:0] FMT_DFRAME_00 = 2'h0;
	localparam logic [1:0] FMT_DFRAME_01 = 2'h1;

	// Timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int MS_IN_NS = 1000000;
	localparam int MS_CYCLES_DEF = (MS_IN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [8:0] T_SHORT_MS = 9'h008;
	localparam logic [8:0] T_LONG_MS = 9'h190;
	localparam logic [4:0] LLB_HOLD_MS = 5'h19;
	localparam logic [11:0] MAX_FRAME_BYTES = 12'hFFF;
	localparam logic [11:0] FRM_START_BYTES = 12'h002;

	// Loopback detector state
	typedef enum logic [0:0] {
		LLB_IDLE = 1'b0,
		LLB_DET = 1'b1
	} fhi_llb_t;

	// One-cycle event pulses from the receive/transmit/framer logic
	typedef struct packed {
		logic rx_start;
		logic rx_addr_valid;
		logic rx_byte;
		logic rx_end;
		logic rx_overflow;
		logic tx_pool_free;
		logic tx_last_bit;
		logic tx_byte_req;
		logic rx_mf_start;
		logic rx_dframe;
		logic tx_mf_start;
		logic cas_update;
		logic submf_done;
		logic crc_fail;
	} fhi_evt_t;

	// Level status from the framer and line logic
	typedef struct packed {
		logic frame_lost;
		logic multiframe_lost_flag;
		logic all_ones_alarm;
		logic signal_absent;
		logic remote_alarm;
		logic ts16_sync;
		logic alarm_sim;
		logic llb_act;
		logic llb_deact;
		logic ber_high;
		logic prbs_sync;
		logic [2:0] sa6_combo;
		logic tx_fifo_empty;
		logic tx_message_end_cmd;
	} fhi_lvl_t;

endpackage : fhi_pkg

// [fhi_host_model.sv]
// Host-side APB master that performs one register transfer per command
`timescale 1ns/10ps

module fhi_host_model
	import fhi_pkg::*;
(
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Command from the bench
	input wire logic go,
	input wire logic wr,
	input wire logic [7:0] idx,
	input wire logic [7:0] wd,
	output logic [31:0] rdata,
	output logic err,
	output logic done,
	// APB master
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [9:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);

	// Setup, access until pready, then release with scrambled address and data
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psel <= 1'h0;
			penable <= 1'h0;
			pwrite <= 1'h0;
			paddr <= 10'h000;
			pwdata <= 32'h0;
			rdata <= 32'h0;
			err <= 1'h0;
			done <= 1'h0;
		end else begin
			done <= 1'h0;
			if (psel && penable && pready) begin
				psel <= 1'h0;
				penable <= 1'h0;
				paddr <= ~paddr; // Stale address must not look valid
				pwdata <= ~pwdata;
				rdata <= prdata;
				err <= pslverr;
				done <= 1'h1;
			end else if (psel) begin
				penable <= 1'h1;
			end else if (go) begin
				psel <= 1'h1;
				pwrite <= wr;
				paddr <= {idx, 2'h0};
				pwdata <= {24'h0, wd};
			end
		end
	end

endmodule : fhi_host_model

// [tb_fhi_irq_status.sv]
// Self-checking testbench of the interrupt status block
`timescale 1ns/10ps

module tb_fhi_irq_status
	import fhi_pkg::*;
;
	localparam int MSC = 20;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel, penable, pwrite, pready, pslverr, err, done;
	logic irq, low_addr_match, tx_disable, sig_copy;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata, rdata;
	logic go = 1'h0;
	logic wr = 1'h0;
	logic [7:0] idx = 8'h00;
	logic [7:0] wd = 8'h00;
	logic [7:0] rx_addr = 8'h00;
	logic [63:0] cas_data = 64'h0;
	fhi_evt_t evt = '0;
	fhi_evt_t ev;
	fhi_lvl_t lvl = '0;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;

	// Clock
	always #2 pclk = ~pclk;

	fhi_irq_status #(.MS_CYCLES(MSC)) fhi_irq_status_i (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .evt(evt), .lvl(lvl),
		.rx_addr(rx_addr), .cas_data(cas_data), .irq(irq), .low_addr_match(low_addr_match),
		.tx_disable(tx_disable), .sig_copy(sig_copy));

	fhi_host_model fhi_host_model_i (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr),
		.idx(idx), .wd(wd), .rdata(rdata), .err(err), .done(done), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));

	// Verdict and end of run
	task summarize;
		if (mismatches == 0 && compares > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : summarize

	// Hang guard
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			summarize();
		end
	end

	// Comparison
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One transfer through the host model, bounded wait
	task xfer(input logic w, input logic [7:0] i, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		go <= 1'h1;
		wr <= w;
		idx <= i;
		wd <= d;
		@(posedge pclk);
		go <= 1'h0;
		while (done !== 1'h1 && n < 40) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 40) mismatches++;
	endtask : xfer

	task rc(input logic [7:0] i, input logic [7:0] e, input string nm);
		xfer(1'h0, i, 8'h00);
		chk(nm, rdata, {24'h0, e});
	endtask : rc

	task wrr(input logic [7:0] i, input logic [7:0] d);
		xfer(1'h1, i, d);
	endtask : wrr

	// One-cycle event, then let it land
	task pulse(input fhi_evt_t e);
		@(posedge pclk);
		evt <= e;
		@(posedge pclk);
		evt <= '0;
		@(posedge pclk);
	endtask : pulse

	// Received frame of n bytes, end with the last byte
	task frame(input int n);
		for (int b = 1; b <= n; b++) begin
			@(posedge pclk);
			evt.rx_start <= (b == 1);
			evt.rx_byte <= 1'h1;
			evt.rx_end <= (b == n);
		end
		@(posedge pclk);
		evt <= '0;
	endtask : frame

	// Main sequence
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'h1;
		chk("irq_rst", irq, 1'h0); // Quiet
		rc(IDX_STAT0, STATUS_RST, "irq_status_0_rst");
		rc(IDX_MASK0, MASK_RST, "mask_rst");
		for (int k = 0; k < 3; k++) wrr(8'(IDX_MASK0 + k), 8'h00);
		wrr(IDX_CFG, 8'h40);
		ev = '0;
		ev.submf_done = 1'h1;
		pulse(ev);
		rc(IDX_STAT0, 8'h00, "crc_ok"); // Pass
		ev.crc_fail = 1'h1;
		pulse(ev);
		chk("irq_on", irq, 1'h1); // Raised
		rc(IDX_SUM, 8'h01, "sum"); // Summary
		rc(IDX_STAT0, 8'h04, "crc_bad"); // Fail
		chk("irq_off", irq, 1'h0); // Dropped
		rc(IDX_STAT0, 8'h00, "clr0"); // Cleared
		wrr(IDX_MASK0, 8'hFF);
		wrr(IDX_CFG, 8'h41);
		pulse(ev);
		chk("irq_msk", irq, 1'h0); // Masked
		rc(IDX_SUM, 8'h00, "sum_msk"); // Masked
		rc(IDX_STAT0, 8'h04, "shown"); // Shown
		wrr(IDX_CFG, 8'h40);
		pulse(ev);
		rc(IDX_STAT0, 8'h00, "hid"); // Hidden
		wrr(IDX_MASK0, 8'h00);
		frame(1);
		rc(IDX_STAT0, 8'h80, "f1"); // Short frame
		frame(32);
		rc(IDX_STAT0, 8'hC0, "f32"); // Start
		rc(IDX_CNT_LO, 8'h20, "cnt32"); // Length
		frame(33);
		rc(IDX_STAT0, 8'hC1, "f33"); // Pool
		rc(IDX_CNT_LO, 8'h21, "cnt33"); // Length
		rc(IDX_CNT_HI, 8'h00, "cnth33"); // Length
		frame(4096);
		rc(IDX_STAT0, 8'hC1, "f4096"); // Long
		rc(IDX_CNT_LO, 8'hFF, "cntmax"); // Saturated
		rc(IDX_CNT_HI, 8'h1F, "exceed"); // Exceeded
		wrr(IDX_CMP1, 8'h5A);
		wrr(IDX_CMP2, 8'h3C);
		rx_addr <= 8'h5A;
		ev = '0;
		ev.rx_addr_valid = 1'h1;
		pulse(ev);
		chk("match1", low_addr_match, 1'h1); // First
		rx_addr <= 8'h3C;
		pulse(ev);
		chk("match2", low_addr_match, 1'h0); // Second
		lvl.tx_fifo_empty <= 1'h1;
		lvl.tx_message_end_cmd <= 1'h1;
		ev = '0;
		ev.tx_byte_req = 1'h1;
		pulse(ev);
		rc(IDX_STAT1, 8'h00, "urun_no"); // Ended
		lvl.tx_message_end_cmd <= 1'h0;
		ev.tx_last_bit = 1'h1;
		ev.rx_overflow = 1'h1;
		ev.tx_pool_free = 1'h1;
		pulse(ev);
		chk("txdis", tx_disable, 1'h1); // Held
		rc(IDX_STAT1, 8'h71, "irq_status_1"); // Flags
		chk("txen", tx_disable, 1'h0); // Released
		@(posedge pclk);
		evt.tx_mf_start <= 1'h1;
		@(posedge pclk);
		evt <= '0;
		chk("copy0", sig_copy, 1'h0); // Order
		@(posedge pclk);
		chk("copy1", sig_copy, 1'h1); // Copy
		@(posedge pclk);
		chk("copy2", sig_copy, 1'h0); // Single
		rc(IDX_STAT1, 8'h08, "txmf"); // Flag
		lvl.frame_lost <= 1'h1;
		rc(IDX_STAT2, 8'h40, "flost"); // Lost
		lvl.frame_lost <= 1'h0;
		rc(IDX_STAT2, 8'h80, "fregain"); // Regained
		lvl.all_ones_alarm <= 1'h1;
		lvl.signal_absent <= 1'h1;
		rc(IDX_STAT2, 8'h0C, "alarm"); // Detected
		lvl.all_ones_alarm <= 1'h0;
		lvl.signal_absent <= 1'h0;
		rc(IDX_STAT2, 8'h00, "alarm_off"); // Level mode
		wrr(IDX_CFG, 8'h42);
		lvl.signal_absent <= 1'h1;
		rc(IDX_STAT2, 8'h04, "nosig_on"); // Change mode
		lvl.signal_absent <= 1'h0;
		rc(IDX_STAT2, 8'h04, "nosig_off"); // Change mode
		wrr(IDX_CFG, 8'h70);
		lvl.multiframe_lost_flag <= 1'h1;
		repeat (8 * MSC - 30) @(posedge pclk);
		rc(IDX_STAT0, 8'h00, "t8_early"); // Window
		repeat (40) @(posedge pclk);
		rc(IDX_STAT0, 8'h20, "t8"); // Short
		repeat (7700) @(posedge pclk);
		rc(IDX_STAT2, 8'h00, "t400_early"); // Window
		repeat (150) @(posedge pclk);
		rc(IDX_STAT2, 8'h10, "t400"); // Long
		lvl.multiframe_lost_flag <= 1'h0;
		rc(IDX_STAT2, 8'h20, "mfregain"); // Multiframe
		ev = '0;
		ev.rx_dframe = 1'h1;
		pulse(ev);
		rc(IDX_STAT0, 8'h00, "mfb_df"); // CRC format
		ev = '0;
		ev.rx_mf_start = 1'h1;
		pulse(ev);
		rc(IDX_STAT0, 8'h10, "mfb_mf"); // CRC format
		wrr(IDX_CFG, 8'h40);
		ev = '0;
		ev.rx_dframe = 1'h1;
		pulse(ev);
		rc(IDX_STAT0, 8'h10, "mfb_00"); // Doubleframe
		wrr(IDX_CFG, 8'h48);
		ev = '0;
		ev.rx_mf_start = 1'h1;
		pulse(ev);
		rc(IDX_STAT0, 8'h10, "mfb_01"); // Format 01
		lvl.ts16_sync <= 1'h1;
		cas_data <= 64'h0123456789ABCDEF;
		ev = '0;
		ev.cas_update = 1'h1;
		pulse(ev);
		rc(IDX_STAT0, 8'h08, "cas_new"); // Differs
		pulse(ev);
		rc(IDX_STAT0, 8'h00, "cas_same"); // Same
		lvl.sa6_combo <= 3'h5;
		rc(IDX_STAT0, 8'h02, "sa6"); // Combination
		wrr(IDX_CFG, 8'h44);
		lvl.prbs_sync <= 1'h1;
		rc(IDX_STAT1, 8'h80, "prbs"); // Synchronizer
		wrr(IDX_CFG, 8'h40);
		lvl.llb_act <= 1'h1;
		repeat (25 * MSC + 20) @(posedge pclk);
		rc(IDX_STAT1, 8'h80, "llb_on"); // Pattern held
		lvl.ber_high <= 1'h1;
		rc(IDX_STAT1, 8'h80, "llb_off"); // Error rate
		xfer(1'h0, 8'h00, 8'h00);
		chk("unmap_err", err, 1'h1);
		chk("unmap_data", rdata, 32'h0);
		summarize();
	end

endmodule : tb_fhi_irq_status
